// *** accumulator_transfer_cfg.svh ***
// Constants for the accumulator transfer decoder: opcodes, widths, resets.
// Assumes inclusion by bare name from the package and the decoder.
`ifndef ACCUMULATOR_TRANSFER_CFG_SVH
`define ACCUMULATOR_TRANSFER_CFG_SVH

// ****************************************************************
// Word widths and register counts
// ****************************************************************
`define INSTR_W 10
`define NIB_W 4
`define ROM_PTR_W 3
`define STACK_W 3
`define BANK_W 2
`define PAIR_W 8
`define TIMER_CNT 6
`define PORT_CNT 3
`define EXT_CNT 2

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_NIB 4'h0
`define RST_ROM_PTR 3'h0
`define RST_PAIR 8'h00

// ****************************************************************
// Opcodes of the group (10-bit words)
// ****************************************************************
`define OPC_READ_ADC_CTRL_2 10'h245
`define OPC_READ_ADC_CTRL_3 10'h246
`define OPC_READ_STACK_INDEX 10'h050
`define OPC_READ_IRQ_CTRL_1 10'h054
`define OPC_READ_IRQ_CTRL_2 10'h055
`define OPC_READ_TIMER_CTRL_1 10'h24B
`define OPC_READ_TIMER_CTRL_6 10'h250
`define OPC_READ_RAM_FILE 10'h052
`define OPC_READ_RAM_WORD 10'h01F
`define OPC_READ_RAM_BANK 10'h053
`define OPC_LOAD_SECOND_ACC 10'h00E
`define OPC_LOAD_ROM_POINTER 10'h029
`define OPC_LOAD_PAIR_BUF 10'h01A
`define OPC_WRITE_PORT_DRIVE_0 10'h228
`define OPC_WRITE_EXT_INT_CTRL_1 10'h217
`define OPC_WRITE_EXT_INT_CTRL_2 10'h218
`define OPC_WRITE_SERIAL_CTRL 10'h202
`define OPC_WRITE_WAKE_CTRL_0 10'h21B

`endif

// *** accumulator_transfer_decoder.sv ***
// Decode and execute of the accumulator transfer instruction group.
// Assumes the fetch sequencer presents one word per machine cycle.
`timescale 1ns/1ps
`default_nettype none
`include "accumulator_transfer_cfg.svh"

// Function
// - Interrupt control reads load full nibble
// - Six timer control reads copy whole nibble
// - Converter control 2/3 reads copy nibble
// - Stack index to bits 2:0, bit3 zero
// - RAM file/word reads copy nibble
// - Bank bits to 1:0, bits 3:2 zero
// - Second accumulator loads, accumulator unchanged
// - ROM pointer takes accumulator bits 2:0
// - Pair buffer gets second acc, accumulator
// - External interrupt writes copy accumulator
// - Serial control write copies accumulator
// - Wakeup control 0 write copies accumulator
// - One word, one cycle, no carry/skip
module accumulator_transfer_decoder
  import accumulator_transfer_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [`INSTR_W-1:0] instr,
  input wire src_s src,
  input wire logic acc_load,
  input wire logic [`NIB_W-1:0] acc_load_data,
  output var state_s regs
);

  // ****************************************************************
  // Opcode decode
  // ****************************************************************

  // Shared by the datapath and the checks below
  function automatic dec_s decode(input logic [`INSTR_W-1:0] w);
    dec_s d;
    d.op = OP_NONE;
    d.idx = 3'h0;
    if (w >= `OPC_READ_TIMER_CTRL_1 && w <= `OPC_READ_TIMER_CTRL_6) begin
      d.op = OP_READ_TIMER_CTRL;
      d.idx = 3'(w - `OPC_READ_TIMER_CTRL_1);
    end else if (w >= `OPC_WRITE_PORT_DRIVE_0 &&
                 w < `OPC_WRITE_PORT_DRIVE_0 + `PORT_CNT) begin
      d.op = OP_WRITE_PORT_DRIVE;
      d.idx = 3'(w - `OPC_WRITE_PORT_DRIVE_0);
    end else begin
      unique case (w)
        `OPC_READ_IRQ_CTRL_1: d.op = OP_READ_IRQ_CTRL_1;
        `OPC_READ_IRQ_CTRL_2: d.op = OP_READ_IRQ_CTRL_2;
        `OPC_READ_ADC_CTRL_2: d.op = OP_READ_ADC_CTRL_2;
        `OPC_READ_ADC_CTRL_3: d.op = OP_READ_ADC_CTRL_3;
        `OPC_READ_STACK_INDEX: d.op = OP_READ_STACK_INDEX;
        `OPC_READ_RAM_FILE: d.op = OP_READ_RAM_FILE;
        `OPC_READ_RAM_WORD: d.op = OP_READ_RAM_WORD;
        `OPC_READ_RAM_BANK: d.op = OP_READ_RAM_BANK;
        `OPC_LOAD_SECOND_ACC: d.op = OP_LOAD_SECOND_ACC;
        `OPC_LOAD_ROM_POINTER: d.op = OP_LOAD_ROM_POINTER;
        `OPC_LOAD_PAIR_BUF: d.op = OP_LOAD_PAIR_BUF;
        `OPC_WRITE_EXT_INT_CTRL_1: d.op = OP_WRITE_EXT_INT_CTRL;
        `OPC_WRITE_EXT_INT_CTRL_2: begin
          d.op = OP_WRITE_EXT_INT_CTRL;
          d.idx = 3'h1;
        end
        `OPC_WRITE_SERIAL_CTRL: d.op = OP_WRITE_SERIAL_CTRL;
        `OPC_WRITE_WAKE_CTRL_0: d.op = OP_WRITE_WAKE_CTRL_0;
        default: d.op = OP_NONE;
      endcase
    end
    return d;
  endfunction : decode

  dec_s dec;
  state_s state_q;
  state_s state_d;

  // Foreign words decode to nothing; invalid cycles likewise
  always_comb begin
    dec = decode(instr);
    if (!instr_valid) begin
      dec.op = OP_NONE;
    end
  end

  // ****************************************************************
  // Execute
  // ****************************************************************

  // Every kind finishes here in one cycle; carry is never touched
  always_comb begin
    state_d = state_q;
    state_d.executed = 1'b0;
    state_d.skip_next = 1'b0;
    // Other groups load the accumulator only when this group is idle
    if (acc_load && dec.op == OP_NONE) begin
      state_d.acc = acc_load_data;
    end
    unique case (dec.op)
      OP_NONE: begin
        state_d.executed = 1'b0;
      end
      OP_READ_IRQ_CTRL_1: state_d.acc = src.irq_ctrl_1;
      OP_READ_IRQ_CTRL_2: state_d.acc = src.irq_ctrl_2;
      OP_READ_TIMER_CTRL: begin
        state_d.acc = src.timer_ctrl[dec.idx];
      end
      OP_READ_ADC_CTRL_2: state_d.acc = src.adc_ctrl_2;
      OP_READ_ADC_CTRL_3: state_d.acc = src.adc_ctrl_3;
      OP_READ_STACK_INDEX: begin
        state_d.acc = {1'b0, src.stack_index};
      end
      OP_READ_RAM_FILE: state_d.acc = src.ram_file;
      OP_READ_RAM_WORD: state_d.acc = src.ram_word;
      OP_READ_RAM_BANK: begin
        state_d.acc = {2'h0, src.ram_bank};
      end
      OP_LOAD_SECOND_ACC: state_d.second_acc = state_q.acc;
      OP_LOAD_ROM_POINTER: begin
        state_d.rom_pointer_hi = state_q.acc[`ROM_PTR_W-1:0];
      end
      OP_LOAD_PAIR_BUF: begin
        state_d.pair_buf = {state_q.second_acc, state_q.acc};
      end
      OP_WRITE_PORT_DRIVE: begin
        state_d.port_drive_ctrl[dec.idx[1:0]] = state_q.acc;
      end
      OP_WRITE_EXT_INT_CTRL: begin
        state_d.ext_int_ctrl[dec.idx[0]] = state_q.acc;
      end
      OP_WRITE_SERIAL_CTRL: state_d.serial_ctrl = state_q.acc;
      OP_WRITE_WAKE_CTRL_0: state_d.wake_ctrl_0 = state_q.acc;
      default: state_d.executed = 1'b0;
    endcase
    if (dec.op != OP_NONE) begin
      state_d.executed = 1'b1;
    end
  end

  // Single register stage: results visible in the following cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign regs = state_q;

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  irq_read_acc_a: assert property (
    dec.op == OP_READ_IRQ_CTRL_2 |=> regs.acc == $past(src.irq_ctrl_2))
    else $error("irq control read wrong");

  timer_read_acc_a: assert property (
    dec.op == OP_READ_TIMER_CTRL |=>
      regs.acc == $past(src.timer_ctrl[dec.idx]))
    else $error("timer control read wrong");

  adc_read_acc_a: assert property (
    dec.op == OP_READ_ADC_CTRL_3 |=> regs.acc == $past(src.adc_ctrl_3))
    else $error("converter control read wrong");

  stack_read_zero_a: assert property (
    dec.op == OP_READ_STACK_INDEX |=>
      regs.acc == {1'b0, $past(src.stack_index)})
    else $error("stack index read wrong");

  ram_word_read_a: assert property (
    dec.op == OP_READ_RAM_WORD |=> regs.acc == $past(src.ram_word))
    else $error("ram word read wrong");

  bank_read_zero_a: assert property (
    dec.op == OP_READ_RAM_BANK |=> regs.acc[3:2] == 2'h0 &&
      regs.acc[1:0] == $past(src.ram_bank))
    else $error("bank read wrong");

  second_acc_load_a: assert property (
    dec.op == OP_LOAD_SECOND_ACC |=> regs.second_acc == $past(regs.acc)
      && $stable(regs.acc))
    else $error("second accumulator load wrong");

  rom_ptr_load_a: assert property (
    dec.op == OP_LOAD_ROM_POINTER |=>
      regs.rom_pointer_hi == $past(regs.acc[2:0]))
    else $error("rom pointer load wrong");

  pair_buf_load_a: assert property (
    dec.op == OP_LOAD_PAIR_BUF |=>
      regs.pair_buf == {$past(regs.second_acc), $past(regs.acc)})
    else $error("pair buffer load wrong");

  port_drive_wr_a: assert property (
    dec.op == OP_WRITE_PORT_DRIVE && dec.idx == 3'h2 |=>
      regs.port_drive_ctrl[2] == $past(regs.acc) &&
      $stable(regs.port_drive_ctrl[0]))
    else $error("port drive write wrong");

  ext_int_wr_a: assert property (
    dec.op == OP_WRITE_EXT_INT_CTRL |=>
      regs.ext_int_ctrl[$past(dec.idx[0])] == $past(regs.acc))
    else $error("external interrupt write wrong");

  serial_wr_a: assert property (
    dec.op == OP_WRITE_SERIAL_CTRL |=> regs.serial_ctrl == $past(regs.acc))
    else $error("serial control write wrong");

  wake_wr_a: assert property (
    dec.op == OP_WRITE_WAKE_CTRL_0 |=> regs.wake_ctrl_0 == $past(regs.acc))
    else $error("wakeup control write wrong");

  one_cycle_exec_a: assert property (
    dec.op != OP_NONE |=> regs.executed && !regs.skip_next ##1
      (regs.executed == $past(dec.op != OP_NONE)))
    else $error("execution not single cycle");

  no_match_hold_a: assert property (
    dec.op == OP_NONE && !acc_load |=> $stable(regs) || $rose(regs.executed)
      || $fell(regs.executed))
    else $error("foreign word changed a register");

  timer_read_c: cover property (dec.op == OP_READ_TIMER_CTRL ##1
    dec.op == OP_LOAD_SECOND_ACC);
  pair_chain_c: cover property (dec.op == OP_LOAD_SECOND_ACC ##1
    dec.op == OP_LOAD_PAIR_BUF);
  port_write_c: cover property (dec.op == OP_WRITE_PORT_DRIVE &&
    dec.idx == 3'h1);
  bank_read_c: cover property (dec.op == OP_READ_RAM_BANK);

endmodule : accumulator_transfer_decoder
`default_nettype wire

// *** accumulator_transfer_pkg.sv ***
// Types for the accumulator transfer decoder.
// Assumes the constants header sits in the include path.
`include "accumulator_transfer_cfg.svh"

package accumulator_transfer_pkg;

  // ****************************************************************
  // Decoded operation kinds
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_NONE,
    OP_READ_IRQ_CTRL_1,
    OP_READ_IRQ_CTRL_2,
    OP_READ_TIMER_CTRL,
    OP_READ_ADC_CTRL_2,
    OP_READ_ADC_CTRL_3,
    OP_READ_STACK_INDEX,
    OP_READ_RAM_FILE,
    OP_READ_RAM_WORD,
    OP_READ_RAM_BANK,
    OP_LOAD_SECOND_ACC,
    OP_LOAD_ROM_POINTER,
    OP_LOAD_PAIR_BUF,
    OP_WRITE_PORT_DRIVE,
    OP_WRITE_EXT_INT_CTRL,
    OP_WRITE_SERIAL_CTRL,
    OP_WRITE_WAKE_CTRL_0
  } op_e;

  // Decoded word: kind plus register index where a kind has several
  typedef struct packed {
    op_e op;
    logic [2:0] idx;
  } dec_s;

  // Source registers read into the accumulator
  typedef struct packed {
    logic [`NIB_W-1:0] irq_ctrl_1;
    logic [`NIB_W-1:0] irq_ctrl_2;
    logic [`TIMER_CNT-1:0][`NIB_W-1:0] timer_ctrl;
    logic [`NIB_W-1:0] adc_ctrl_2;
    logic [`NIB_W-1:0] adc_ctrl_3;
    logic [`STACK_W-1:0] stack_index;
    logic [`NIB_W-1:0] ram_file;
    logic [`NIB_W-1:0] ram_word;
    logic [`BANK_W-1:0] ram_bank;
  } src_s;

  // Whole state of the decoder, also its output bundle
  typedef struct packed {
    logic [`NIB_W-1:0] acc;
    logic [`NIB_W-1:0] second_acc;
    logic [`ROM_PTR_W-1:0] rom_pointer_hi;
    logic [`PAIR_W-1:0] pair_buf;
    logic [`PORT_CNT-1:0][`NIB_W-1:0] port_drive_ctrl;
    logic [`EXT_CNT-1:0][`NIB_W-1:0] ext_int_ctrl;
    logic [`NIB_W-1:0] serial_ctrl;
    logic [`NIB_W-1:0] wake_ctrl_0;
    logic executed;
    logic skip_next;
  } state_s;

endpackage : accumulator_transfer_pkg

// *** fetch_seq_model.sv ***
// Behavioural fetch sequencer that hands one word to the decoder per cycle.
// Assumes the bench calls present once per cycle, at the falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "accumulator_transfer_cfg.svh"

module fetch_seq_model (
  output var logic instr_valid,
  output var logic [`INSTR_W-1:0] instr
);
  // ****************************************************************
  // Word presentation
  // ****************************************************************
  initial begin
    instr_valid = 1'b0;
    instr = 10'h000;
  end

  // Idle words flip every cycle so a stale word never looks valid
  task automatic present(input logic v, input logic [`INSTR_W-1:0] w);
    instr_valid = v;
    instr = v ? w : ~instr;
  endtask : present
endmodule : fetch_seq_model
`default_nettype wire

// *** test_accumulator_transfer_decoder.sv ***
// Self-checking bench for the accumulator transfer decoder.
// Assumes the package and constants header are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
`include "accumulator_transfer_cfg.svh"

module test_accumulator_transfer_decoder
  import accumulator_transfer_pkg::*;
;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid;
  logic [`INSTR_W-1:0] instr;
  src_s src = '0;
  logic acc_load = 1'b0;
  logic [`NIB_W-1:0] acc_load_data = 4'h0;
  state_s regs;
  state_s exp_q = '0;
  int bad_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h0000_0009;
  logic [`INSTR_W-1:0] ops [25];
  logic [`INSTR_W-1:0] singles [16] = '{`OPC_READ_ADC_CTRL_2,
    `OPC_READ_ADC_CTRL_3, `OPC_READ_STACK_INDEX, `OPC_READ_IRQ_CTRL_1,
    `OPC_READ_IRQ_CTRL_2, `OPC_READ_RAM_FILE, `OPC_READ_RAM_WORD,
    `OPC_READ_RAM_BANK, `OPC_LOAD_SECOND_ACC, `OPC_LOAD_ROM_POINTER,
    `OPC_LOAD_PAIR_BUF, `OPC_WRITE_EXT_INT_CTRL_1,
    `OPC_WRITE_EXT_INT_CTRL_2, `OPC_WRITE_SERIAL_CTRL,
    `OPC_WRITE_WAKE_CTRL_0, 10'h3FF};

  always #4 clk = ~clk;

  fetch_seq_model fetch (.instr_valid(instr_valid), .instr(instr));

  accumulator_transfer_decoder i_accumulator_transfer_decoder (
    .clk(clk),
    .rst_n(rst_n),
    .instr_valid(instr_valid),
    .instr(instr),
    .src(src),
    .acc_load(acc_load),
    .acc_load_data(acc_load_data),
    .regs(regs)
  );

  // ****************************************************************
  // Expectation and helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Register image one edge later; group words win over acc_load
  function automatic state_s next_state(state_s e, logic v,
      logic [`INSTR_W-1:0] w, src_s s, logic ld, logic [`NIB_W-1:0] d);
    logic hit;
    hit = v;
    if (!v)
      hit = 1'b0;
    else if (w inside {[`OPC_READ_TIMER_CTRL_1:`OPC_READ_TIMER_CTRL_6]})
      e.acc = s.timer_ctrl[w - `OPC_READ_TIMER_CTRL_1];
    else if (w inside {[`OPC_WRITE_PORT_DRIVE_0:10'h22A]})
      e.port_drive_ctrl[w - `OPC_WRITE_PORT_DRIVE_0] = e.acc;
    else begin
      case (w)
        `OPC_READ_ADC_CTRL_2: e.acc = s.adc_ctrl_2;
        `OPC_READ_ADC_CTRL_3: e.acc = s.adc_ctrl_3;
        `OPC_READ_STACK_INDEX: e.acc = {1'b0, s.stack_index};
        `OPC_READ_IRQ_CTRL_1: e.acc = s.irq_ctrl_1;
        `OPC_READ_IRQ_CTRL_2: e.acc = s.irq_ctrl_2;
        `OPC_READ_RAM_FILE: e.acc = s.ram_file;
        `OPC_READ_RAM_WORD: e.acc = s.ram_word;
        `OPC_READ_RAM_BANK: e.acc = {2'b00, s.ram_bank};
        `OPC_LOAD_SECOND_ACC: e.second_acc = e.acc;
        `OPC_LOAD_ROM_POINTER: e.rom_pointer_hi = e.acc[2:0];
        `OPC_LOAD_PAIR_BUF: e.pair_buf = {e.second_acc, e.acc};
        `OPC_WRITE_EXT_INT_CTRL_1: e.ext_int_ctrl[0] = e.acc;
        `OPC_WRITE_EXT_INT_CTRL_2: e.ext_int_ctrl[1] = e.acc;
        `OPC_WRITE_SERIAL_CTRL: e.serial_ctrl = e.acc;
        `OPC_WRITE_WAKE_CTRL_0: e.wake_ctrl_0 = e.acc;
        default: hit = 1'b0;
      endcase
    end
    e.executed = hit;
    e.skip_next = 1'b0;
    if (!hit && ld)
      e.acc = d;
    return e;
  endfunction : next_state

  task automatic check(input state_s got, input state_s want,
      input string what);
    samples_checked++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, got);
    end
  endtask : check

  // Compare last edge, then present fresh word and random sources
  task automatic step(input logic v, input logic [`INSTR_W-1:0] w,
      input logic ld);
    logic [63:0] r;
    @(negedge clk);
    check(regs, exp_q, "regs");
    r = {rnd(), rnd()};
    src = r[$bits(src_s)-1:0];
    acc_load = ld;
    acc_load_data = r[63:60];
    fetch.present(v, w);
    exp_q = next_state(exp_q, v, w, src, ld, acc_load_data);
  endtask : step

  // Mostly group words, some stray words and idle cycles
  task automatic burst(input int n);
    logic [31:0] r;
    repeat (n) begin
      r = rnd();
      if (r[1:0] != 2'b00)
        step(1'b1, ops[r[9:4] % 25], r[2]);
      else
        step(r[3], r[13:4], r[2]);
    end
  endtask : burst

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    for (int k = 0; k < 6; k++) begin
      ops[k] = `OPC_READ_TIMER_CTRL_1 + 10'(k);
    end
    for (int k = 0; k < 3; k++) begin
      ops[6 + k] = `OPC_WRITE_PORT_DRIVE_0 + 10'(k);
    end
    for (int k = 0; k < 16; k++) begin
      ops[9 + k] = singles[k];
    end
    ops[24] = `OPC_READ_ADC_CTRL_2;
    repeat (10) @(posedge clk);
    check(regs, '0, "reset");
    @(negedge clk);
    rst_n = 1'b1;
    // Short walk: load, copy to second acc, pair back to back
    step(1'b0, 10'h000, 1'b1);
    step(1'b1, `OPC_LOAD_SECOND_ACC, 1'b0);
    step(1'b1, `OPC_LOAD_PAIR_BUF, 1'b0);
    // Every code after a fresh acc, then all back to back
    for (int k = 0; k < 25; k++) begin
      step(1'b0, 10'h000, 1'b1);
      step(1'b1, ops[k], 1'b1);
    end
    for (int k = 0; k < 25; k++) begin
      step(1'b1, ops[k], 1'b1);
    end
    burst(2000);
    // Second reset in mid-run
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    check(regs, '0, "reset");
    rst_n = 1'b1;
    exp_q = '0;
    burst(1000);
    step(1'b0, 10'h000, 1'b0);
    print_verdict();
  end

  // Hang guard
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end
endmodule : test_accumulator_transfer_decoder
`default_nettype wire
